// File: core/rcdsw_top.sv
// deep sleep wake-up sequencer with ahb-lite registers
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module rcdsw_top
  import rcdsw_pkg::*;
(
  input wire logic hclk, // bus clock, 250 MHz
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  input wire logic low_power_clock, // low-power clock, sampled as a pin
  input wire logic radio_domain_up_flag, // radio domain powered, from pmu
  output logic early_wake_irq, // early wake interrupt
  output logic sleep_exit_irq, // sleep-exit interrupt pulse
  output logic asleep // core in deep sleep
);
  logic lp_s, lp_d, lp_tick, radio_up;
  logic [31:0] period;
  rcdsw_timing_t timing;
  logic sleep_on, ext_dis, wake_req, clk_en;
  logic [31:0] sleep_duration_cycles;
  logic [31:0] remain, elapsed;
  logic [9:0] ext_cnt;
  logic ext_active;
  logic [15:0] slot_cnt;
  logic [31:0] slot_count;
  rcdsw_state_t state;
  logic ap_valid, ap_write;
  logic [7:0] ap_addr;
  // next values
  logic [31:0] next_period, next_sdur, next_remain, next_elapsed, next_hrdata, next_slot_count;
  rcdsw_timing_t next_timing;
  logic next_sleep_on, next_ext_dis, next_wake_req, next_clk_en, next_early, next_exit, next_ext_active;
  logic [9:0] next_ext_cnt;
  logic [15:0] next_slot_cnt;
  rcdsw_state_t next_state;
  logic next_ap_valid, next_ap_write;
  logic [7:0] next_ap_addr;
  logic req_eff, wr_en, rd_en, timer_expired;

  // low-power clock edge as a tick, radio flag filtered (pins)
  rcdsw_sync3 u_lp (.clk(hclk), .rst_n(hresetn), .ce(ce), .din(low_power_clock), .dout(lp_s));
  rcdsw_sync3 u_rad (.clk(hclk), .rst_n(hresetn), .ce(ce), .din(radio_domain_up_flag), .dout(radio_up));
  assign lp_tick = lp_s & ~lp_d;

  // software bits are written in this domain and act on any hclk cycle, not only on low-power ticks,
  // so they are already stable when sampled there
  assign req_eff = wake_req & ~ext_dis;
  assign timer_expired = (remain == 32'h0);

  function automatic logic lead_hit(input logic [31:0] rem, input logic [9:0] lead);
    lead_hit = (rem == {22'h0, lead});
  endfunction

  assign wr_en = ap_valid & ap_write;
  assign rd_en = hsel & hready & htrans[1] & ~hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign asleep = (state != RCDSW_AWAKE);

  always_comb begin
    next_ap_valid = hsel & hready & htrans[1];
    next_ap_write = hwrite;
    next_ap_addr = haddr[7:0];
    next_period = period;
    next_timing = timing;
    next_sleep_on = sleep_on;
    next_ext_dis = ext_dis;
    next_wake_req = wake_req;
    next_clk_en = clk_en;
    if (wr_en) begin
      unique case (ap_addr)
        OFS_CONTROL: begin
          next_sleep_on = hwdata[CTL_SLEEP_ON_BIT];
          next_ext_dis = hwdata[CTL_EXT_DIS_BIT];
        end
        OFS_PERIOD: next_period = hwdata;
        OFS_TIMING: begin
          next_timing.set_lead = hwdata[TIM_SET_LSB +: TIM_FIELD_W];
          next_timing.clear_lead = hwdata[TIM_CLR_LSB +: TIM_FIELD_W];
          next_timing.ext_len = hwdata[TIM_EXT_LSB +: TIM_FIELD_W];
        end
        OFS_GENERAL: begin
          next_wake_req = hwdata[GEN_WAKE_REQ_BIT];
          next_clk_en = hwdata[GEN_CLK_EN_BIT];
        end
        default: ;
      endcase
    end
    // sleep_on clears itself on exit, so software has to re-arm every sleep
    if (next_state == RCDSW_AWAKE && state != RCDSW_AWAKE) next_sleep_on = 1'b0;
    next_hrdata = 32'h0;
    if (rd_en) begin
      unique case (haddr[7:0])
        OFS_CONTROL: next_hrdata = {30'h0, ext_dis, sleep_on};
        OFS_PERIOD: next_hrdata = period;
        OFS_STATUS: next_hrdata = sleep_duration_cycles;
        OFS_TIMING: next_hrdata = {2'h0, timing.ext_len, timing.clear_lead, timing.set_lead};
        OFS_GENERAL: next_hrdata = {30'h0, clk_en, wake_req};
        OFS_STATE: next_hrdata = {slot_count[15:0], 13'h0, early_wake_irq, asleep, radio_up};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_remain = remain;
    next_elapsed = elapsed;
    next_sdur = sleep_duration_cycles;
    next_early = early_wake_irq;
    next_exit = 1'b0;
    next_ext_cnt = ext_cnt;
    next_ext_active = ext_active;
    next_slot_cnt = slot_cnt;
    next_slot_count = slot_count;
    unique case (state)
      RCDSW_AWAKE: begin
        next_ext_active = 1'b0;
        if (sleep_on && !req_eff) begin
          next_state = RCDSW_SLEEP;
          next_remain = period;
          next_elapsed = 32'h0;
          next_early = 1'b0;
          next_slot_cnt = 16'h0;
        end
      end
      RCDSW_SLEEP, RCDSW_EXPIRED: begin
        if (lp_tick) begin
          next_elapsed = elapsed + 32'h1;
          if (slot_cnt == SLOT_LP_CYCLES - 16'h1) begin
            next_slot_cnt = 16'h0;
            next_slot_count = slot_count + 32'h1;
          end else begin
            next_slot_cnt = slot_cnt + 16'h1;
          end
          if (!timer_expired && !ext_active) begin
            next_remain = remain - 32'h1;
            if (lead_hit(remain, timing.set_lead)) next_early = 1'b1;
            if (lead_hit(remain, timing.clear_lead)) next_early = 1'b0;
          end
          if (ext_active) begin
            if (ext_cnt > timing.clear_lead) next_ext_cnt = ext_cnt - 10'h1;
            else next_early = 1'b0;
          end
        end
        if (timer_expired) next_state = RCDSW_EXPIRED;
        if (state == RCDSW_EXPIRED && clk_en && radio_up && !early_wake_irq) begin
          next_state = RCDSW_AWAKE;
          next_exit = 1'b1;
          next_sdur = elapsed;
        end
      end
      default: next_state = RCDSW_AWAKE;
    endcase
    // evaluated last so a tick in the same cycle cannot undo the forced expiry;
    // a request landing on the exit cycle would leave the early irq stuck while awake
    if (req_eff && !ext_active && state != RCDSW_AWAKE && !next_exit) begin
      next_early = 1'b1;
      next_ext_active = 1'b1;
      next_ext_cnt = timing.ext_len;
      next_remain = 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_d <= 1'b0;
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= RST_ZERO;
      period <= RST_PERIOD;
      timing <= rcdsw_timing_t'(RST_TIMING[29:0]);
      sleep_on <= 1'b0;
      ext_dis <= 1'b0;
      wake_req <= 1'b0;
      clk_en <= 1'b0;
      state <= RCDSW_AWAKE;
      remain <= RST_ZERO;
      elapsed <= RST_ZERO;
      sleep_duration_cycles <= RST_ZERO;
      early_wake_irq <= 1'b0;
      sleep_exit_irq <= 1'b0;
      ext_cnt <= 10'h000;
      ext_active <= 1'b0;
      slot_cnt <= 16'h0000;
      slot_count <= RST_ZERO;
    end else if (ce) begin
      lp_d <= lp_s;
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
      period <= next_period;
      timing <= next_timing;
      sleep_on <= next_sleep_on;
      ext_dis <= next_ext_dis;
      wake_req <= next_wake_req;
      clk_en <= next_clk_en;
      state <= next_state;
      remain <= next_remain;
      elapsed <= next_elapsed;
      sleep_duration_cycles <= next_sdur;
      early_wake_irq <= next_early;
      sleep_exit_irq <= next_exit;
      ext_cnt <= next_ext_cnt;
      ext_active <= next_ext_active;
      slot_cnt <= next_slot_cnt;
      slot_count <= next_slot_count;
    end
  end

  sequence s_exit_cond;
    state == RCDSW_EXPIRED && clk_en && radio_up && !early_wake_irq && ce;
  endsequence

  AST_EXIT_NEEDS_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sleep_exit_irq) |-> $past(clk_en) && $past(radio_up) && $past(state) == RCDSW_EXPIRED)
    else $error("sleep exit without all conditions");
  AST_EXIT_WHEN_READY: assert property (@(posedge hclk) disable iff (!hresetn)
    s_exit_cond |=> sleep_exit_irq && state == RCDSW_AWAKE)
    else $error("ready core did not exit");
  AST_NO_EXIT_NOT_EXPIRED: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_exit_irq |-> $past(timer_expired))
    else $error("exit before expiry or request");
  AST_REQ_IRQ_NOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && req_eff && !ext_active && state != RCDSW_AWAKE &&
     !(state == RCDSW_EXPIRED && clk_en && radio_up && !early_wake_irq)) |=> early_wake_irq)
    else $error("wake request did not raise early irq");
  AST_NO_SLEEP_ON_REQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == RCDSW_AWAKE && req_eff) |=> state == RCDSW_AWAKE)
    else $error("entered sleep with wake request high");
  AST_DISABLE_IGNORES: assert property (@(posedge hclk) disable iff (!hresetn)
    (ext_dis && state == RCDSW_SLEEP && !ext_active) |=> !ext_active)
    else $error("request acted on while disabled");
  AST_STATUS_ON_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sleep_exit_irq) |-> sleep_duration_cycles == $past(elapsed))
    else $error("status not equal to elapsed time");
  AST_EARLY_BEFORE_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_exit_irq |-> !early_wake_irq ##1 !sleep_exit_irq)
    else $error("exit irq order broken");
  AST_SET_LEAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && lp_tick && state == RCDSW_SLEEP && !ext_active && remain != 32'h0 &&
     lead_hit(remain, timing.set_lead) && !lead_hit(remain, timing.clear_lead)) |=> early_wake_irq)
    else $error("early irq not set at lead");
endmodule

// File: core/rcdsw_pkg.sv
// package: register map, field layout and state encoding of the deep sleep wake-up block
package rcdsw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TIMING = 8'h0C;
  localparam logic [7:0] OFS_GENERAL = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  // control register bits
  localparam int CTL_SLEEP_ON_BIT = 0;
  localparam int CTL_EXT_DIS_BIT = 1;
  // general control register bits
  localparam int GEN_WAKE_REQ_BIT = 0;
  localparam int GEN_CLK_EN_BIT = 1;
  // state register bits
  localparam int ST_RADIO_UP_BIT = 0;
  localparam int ST_ASLEEP_BIT = 1;
  localparam int ST_EARLY_BIT = 2;
  // timing register fields
  localparam int TIM_SET_LSB = 0;
  localparam int TIM_CLR_LSB = 10;
  localparam int TIM_EXT_LSB = 20;
  localparam int TIM_FIELD_W = 10;
  // reset values
  localparam logic [31:0] RST_PERIOD = 32'h0000_0000;
  localparam logic [31:0] RST_TIMING = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // slot timing reference
  localparam int SLOT_US = 625;
  localparam int LP_CLK_HZ = 32768;
  localparam logic [15:0] SLOT_LP_CYCLES = 16'(SLOT_US * LP_CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    RCDSW_AWAKE = 2'b00,
    RCDSW_SLEEP = 2'b01,
    RCDSW_EXPIRED = 2'b11
  } rcdsw_state_t;

  typedef struct packed {
    logic [9:0] set_lead;
    logic [9:0] clear_lead;
    logic [9:0] ext_len;
  } rcdsw_timing_t;
endpackage

// File: core/rcdsw_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rcdsw_sync3 (
  input wire logic clk, // sampling clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic din, // asynchronous level
  output logic dout // filtered level
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_dout;

  always_comb begin
    next_stage = {stage[1:0], din};
    // first stage feeds only the second; a change counts once stages two and three agree
    next_dout = (stage[1] == stage[2]) ? stage[2] : dout;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h0;
      dout <= 1'b0;
    end else if (ce) begin
      stage <= next_stage;
      dout <= next_dout;
    end
  end
endmodule

// File: bench/rcdsw_pmu_model.sv
// power unit and low-power clock source facing the wake-up block
`timescale 1ns/1ps
module rcdsw_pmu_model (
  input wire logic hclk, // core clock
  input wire logic power_req, // software asks for the radio domain
  input wire logic [7:0] up_delay, // core cycles until the domain reports up
  output logic low_power_clock, // free-running sleep clock
  output logic radio_domain_up_flag // radio domain powered
);
  logic [7:0] cnt = 8'h00;
  // the sleep clock runs free, 32 core cycles per period, unrelated to bus traffic
  initial begin
    low_power_clock = 1'b0;
    forever begin
      repeat (16) @(posedge hclk);
      low_power_clock <= ~low_power_clock;
    end
  end
  always @(posedge hclk) begin
    cnt <= !power_req ? 8'h00 : (cnt < up_delay ? cnt + 8'h01 : cnt);
  end
  // the flag drops at once on power-down but rises only after the ramp
  assign radio_domain_up_flag = power_req && cnt >= up_delay;
endmodule

// File: bench/rcdsw_top_tb.sv
// self-checking bench for the deep sleep wake-up sequencer
`timescale 1ns/1ps
module rcdsw_top_tb;
  import rcdsw_pkg::*;
  logic hclk, hresetn, hsel, hwrite, pwr_req, rd_dp, found, ce_r;
  logic [31:0] haddr, hwdata, hrdata, rd_last, lfsr;
  logic [1:0] htrans;
  logic [7:0] up_dly;
  logic hreadyout, hresp, lpc, radio_up, early_wake_irq, sleep_exit_irq, asleep;
  logic [63:0] q[$];
  int n_errors = 0;
  int n_checks = 0;
  int cyc;
  rcdsw_top rcdsw_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce_r), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .low_power_clock(lpc), .radio_domain_up_flag(radio_up), .early_wake_irq(early_wake_irq),
    .sleep_exit_irq(sleep_exit_irq), .asleep(asleep));
  rcdsw_pmu_model rcdsw_pmu_model_i (.hclk(hclk), .power_req(pwr_req), .up_delay(up_dly),
    .low_power_clock(lpc), .radio_domain_up_flag(radio_up));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // single word transfer; a read leaves its masked expectation for the monitor
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [63:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w)
      q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
    @(negedge hclk);
  endtask
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && q.size() > 0) begin
      rd_last = hrdata;
      chk(hrdata & q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
  end
  // sel 0 early irq high, 1 exit pulse, 2 asleep, 3 early irq low
  task automatic wait_on(input int sel, input int n, output logic hit);
    hit = 1'b0;
    for (cyc = 0; cyc < n; cyc++) begin
      @(posedge hclk);
      if ((sel == 0 && early_wake_irq === 1'b1) || (sel == 1 && sleep_exit_irq === 1'b1) ||
          (sel == 2 && asleep === 1'b1) || (sel == 3 && early_wake_irq === 1'b0)) begin
        hit = 1'b1;
        break;
      end
    end
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {hresetn, hsel, hwrite, pwr_req, rd_dp, htrans, haddr, hwdata} = '0;
    ce_r = 1'b1;
    lfsr = 32'h4F53765D;
    up_dly = 8'h10;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      xfer(1'b0, 8'(4 * i), 32'h0, {32'hFFFFFFFF, 32'h0});
    xfer(1'b1, 8'h18, 32'hFFFFFFFF, 64'h0);
    xfer(1'b0, 8'h18, 32'h0, {32'hFFFFFFFF, 32'h0});
    lfsr = next_rand(lfsr);
    xfer(1'b1, OFS_PERIOD, lfsr & 32'h3FF, 64'h0);
    xfer(1'b0, OFS_PERIOD, 32'h0, {32'hFFFFFFFF, lfsr & 32'h3FF});
    up_dly <= lfsr[15:8];
    xfer(1'b1, OFS_TIMING, 32'h00200404, 64'h0);
    xfer(1'b0, OFS_TIMING, 32'h0, {32'hFFFFFFFF, 32'h00200404});
    // timed exit with late power-up
    xfer(1'b1, OFS_PERIOD, 32'hA, 64'h0);
    xfer(1'b1, OFS_CONTROL, 32'h1, 64'h0);
    wait_on(2, 200, found); chk(found, 1);
    xfer(1'b0, OFS_STATE, 32'h0, {32'h2, 32'h2});
    wait_on(0, 600, found); chk(found, 1);
    wait_on(3, 200, found); chk(found, 1);
    wait_on(1, 1500, found); chk(found, 0);
    xfer(1'b1, OFS_GENERAL, 32'h2, 64'h0);
    wait_on(1, 600, found); chk(found, 0);
    // clock enable low freezes the sequencer, so the radio coming up must not be seen yet
    ce_r <= 1'b0;
    pwr_req <= 1'b1;
    wait_on(1, 400, found); chk(found, 0);
    ce_r <= 1'b1;
    wait_on(1, 1000, found); chk(found, 1);
    chk(asleep, 0);
    xfer(1'b0, OFS_STATUS, 32'h0, 64'h0);
    chk(rd_last > 32'hA, 1);
    // software request while asleep
    pwr_req <= 1'b0;
    up_dly <= 8'hF0;
    xfer(1'b1, OFS_GENERAL, 32'h0, 64'h0);
    xfer(1'b1, OFS_PERIOD, 32'h1F4, 64'h0);
    xfer(1'b1, OFS_CONTROL, 32'h1, 64'h0);
    wait_on(2, 200, found); chk(found, 1);
    xfer(1'b1, OFS_GENERAL, 32'h1, 64'h0);
    wait_on(0, 300, found); chk(found, 1);
    // high for the part period up to the first tick, then ext_len minus clear_lead whole periods
    wait_on(3, 200, found); chk(found && cyc > 31 && cyc < 64, 1);
    xfer(1'b1, OFS_GENERAL, 32'h3, 64'h0);
    pwr_req <= 1'b1;
    wait_on(1, 1000, found); chk(found, 1);
    chk(early_wake_irq, 0);
    xfer(1'b0, OFS_STATUS, 32'h0, 64'h0);
    chk(rd_last < 32'h1F4, 1);
    xfer(1'b1, OFS_CONTROL, 32'h1, 64'h0);
    wait_on(2, 300, found); chk(found, 0);
    // request masked by the disable bit; the timer still ends sleep
    pwr_req <= 1'b0;
    xfer(1'b1, OFS_GENERAL, 32'h0, 64'h0);
    xfer(1'b1, OFS_CONTROL, 32'h3, 64'h0);
    wait_on(2, 300, found); chk(found, 1);
    xfer(1'b1, OFS_GENERAL, 32'h1, 64'h0);
    wait_on(0, 600, found); chk(found, 0);
    wait_on(0, 17000, found); chk(found, 1);
    xfer(1'b1, OFS_GENERAL, 32'h2, 64'h0);
    pwr_req <= 1'b1;
    wait_on(1, 1000, found); chk(found, 1);
    // the slot count, summed over all sleeps so far, covers at least the 500 programmed ticks
    xfer(1'b0, OFS_STATE, 32'h0, 64'h0);
    chk(rd_last[31:16] >= 16'(32'h1F4 / SLOT_LP_CYCLES), 1);
    print_verdict();
  end
endmodule
